// *** common/gpm_defines.svh ***
// Constants of the pin function multiplexer
`ifndef GPM_DEFINES_SVH
`define GPM_DEFINES_SVH
// Register byte addresses
`define GPM_CON0_ADDR 32'hffff_f400
`define GPM_CON1_ADDR 32'hffff_f404
`define GPM_CON2_ADDR 32'hffff_f408
`define GPM_DAT0_ADDR 32'hffff_f420
`define GPM_SET0_ADDR 32'hffff_f424
`define GPM_PAR0_ADDR 32'hffff_f42c
`define GPM_DAT1_ADDR 32'hffff_f430
`define GPM_SET1_ADDR 32'hffff_f434
`define GPM_PAR1_ADDR 32'hffff_f43c
`define GPM_DAT2_ADDR 32'hffff_f440
`define GPM_SET2_ADDR 32'hffff_f444
`define GPM_PAR2_ADDR 32'hffff_f44c
`define GPM_PLL_ADDR 32'hffff_f450
`define GPM_RCFG_ADDR 32'hffff_f454
// Reset values
`define GPM_CON0_RST 32'h0000_1111
`define GPM_CON_RST 32'h0000_0000
`define GPM_PAR0_RST 32'h2222_0000
`define GPM_PAR1_RST 32'h2200_0022
`define GPM_PAR2_RST 32'h0000_0000
`define GPM_CLK_MODE_RST 2'h1
// Field masks
`define GPM_CON_MASK 32'h3333_3333
`define GPM_PAR0_WMASK 32'h7771_1001
`define GPM_PAR1_WMASK 32'h7711_1111
`define GPM_PAR2_WMASK 32'h0001_1100
`define GPM_DRV_MASK 32'h6666_6666
`define GPM_JTAG_CON 16'h1111
`define GPM_P2_PINS 8'h1d
// Field positions
`define GPM_DAT_DIR_LSB 24
`define GPM_DAT_OUT_LSB 16
`define GPM_DAT_RST_LSB 8
`define GPM_SEL_STRIDE 4
`define GPM_DRV_LSB 1
`define GPM_JTAG_PINS 4
`define GPM_CLK_PIN 10
`define GPM_P2_BASE 16
`define GPM_RCFG_KEEP 0
// Selector codes and timing
`define GPM_SEL_GPIO 2'h0
`define GPM_SEL_FN1 2'h1
`define GPM_SEL_FN2 2'h2
`define GPM_SEL_LA 2'h3
`define GPM_CLK_MODE_EXT 2'h3
`define GPM_INIT_CYCLES 2'h3
`endif

// *** common/gpm_pkg.sv ***
// Types of the pin function multiplexer
package gpm_pkg;
   typedef struct packed {
      logic [2:0][31:0] con;
      logic [2:0][31:0] par;
      logic [2:0][7:0] dir;
      logic [2:0][7:0] dout;
      logic [2:0][7:0] rst_pins;
      logic [2:0] drv_lock;
      logic [1:0] clk_mode;
      logic keep_cfg;
      logic [1:0] init_cnt;
      logic init_done;
      logic [23:0] sync_a;
      logic [23:0] sync_b;
      logic [23:0] la_in;
      logic [31:0] rdata;
      logic [23:0] pad_out;
      logic [23:0] pad_oe_n;
      logic [23:0] pullup_en;
      logic [47:0] drive;
   } gpm_state_t;
endpackage : gpm_pkg

// *** dv/gpm_pins.sv ***
// Model of the pads and the outside world around the pin multiplexer
`timescale 1ns/1ns
module gpm_pins (
   input wire logic core_clk,
   input wire logic [23:0] pad_out,
   input wire logic [23:0] pad_oe_n,
   input wire logic [23:0] pad_pullup_en,
   input wire logic [23:0] ext_en,
   input wire logic [23:0] ext_val,
   output logic [23:0] pad_in
);
   logic [23:0] float_val = 24'h00_0000;
   // Floating pads wander every cycle
   always @(posedge core_clk)
   begin
      float_val <= ~float_val;
   end
   // Block driver wins, then external source, then pull-up
   always_comb
   begin
      for (int i = 0; i < 24; i++)
      begin
         if (!pad_oe_n[i])
            pad_in[i] = pad_out[i];
         else if (ext_en[i])
            pad_in[i] = ext_val[i];
         else if (pad_pullup_en[i])
            pad_in[i] = 1'b1;
         else
            pad_in[i] = float_val[i];
      end
   end
endmodule : gpm_pins

// *** dv/tb_top.sv ***
// Self-checking bench of the pin multiplexer
`timescale 1ns/1ns
`include "gpm_defines.svh"
module tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] bus_addr = 32'h0000_0000;
   logic [31:0] bus_wdata = 32'h0000_0000;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [31:0] bus_rdata;
   logic [23:0] pad_in, pad_out, pad_oe_n, pad_pullup_en, la_in;
   logic [47:0] pad_drive;
   logic [23:0] fn1_out = 24'h00_0000;
   logic [23:0] fn1_drive = 24'h00_0000;
   logic [23:0] fn2_out = 24'h00_0000;
   logic [23:0] fn2_drive = 24'h00_0000;
   logic [23:0] la_out = 24'h00_0000;
   logic [23:0] la_drive = 24'h00_0000;
   logic [23:0] ext_en = 24'hff_ffff;
   logic [23:0] ext_val = 24'hff_ffff;
   logic low_power = 1'b0;
   logic soft_reset = 1'b0;
   logic [1:0] pll_mode = 2'h1;
   int error_cnt = 0;
   int cmp_count = 0;
   // Clock at 20 MHz
   always #25 core_clk = ~core_clk;
   gpm_mux dut_u (.core_clk(core_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
      .pad_drive(pad_drive), .fn1_out(fn1_out), .fn1_drive(fn1_drive), .fn2_out(fn2_out),
      .fn2_drive(fn2_drive), .logic_array_output(la_out), .la_drive(la_drive),
      .logic_array_input(la_in), .low_power(low_power), .soft_reset(soft_reset));
   gpm_pins pins_u (.core_clk(core_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
      .pad_pullup_en(pad_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic print_verdict;
      $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      #1;
      chk($sformatf("register %h", a), exp, bus_rdata);
   endtask : rdchk
   task automatic do_reset(input logic boot);
      @(posedge core_clk);
      rst <= 1'b1;
      ext_val[0] <= boot;
      pll_mode <= 2'h1;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      settle(8);
   endtask : do_reset
   task automatic pulse_soft;
      @(posedge core_clk);
      soft_reset <= 1'b1;
      @(posedge core_clk);
      soft_reset <= 1'b0;
   endtask : pulse_soft
   // Expected {enable_n, level} of pad i for its selector
   function automatic logic [1:0] exp_pad(input int i, input logic [1:0] s, input logic d,
      input logic o);
      case (s)
         2'h0: exp_pad = {~d, o};
         2'h1: exp_pad = {~fn1_drive[i], fn1_out[i]};
         2'h2: exp_pad = (i == 10) ? {pll_mode == 2'h3, fn2_out[i]} : {~fn2_drive[i], fn2_out[i]};
         default: exp_pad = {~la_drive[i], la_out[i]};
      endcase
   endfunction : exp_pad
   task automatic check_pads(input int p, input logic [31:0] c, input logic [7:0] d,
      input logic [7:0] o, input logic [7:0] m);
      logic [1:0] e;
      for (int j = 0; j < 8; j++)
      begin
         e = exp_pad(p * 8 + j, c[4 * j +: 2], d[j], o[j]);
         if (m[j])
            chk("pad_oe_n", {31'h0, e[1]}, {31'h0, pad_oe_n[p * 8 + j]});
         if (m[j] && !e[1])
            chk("pad_out", {31'h0, e[0]}, {31'h0, pad_out[p * 8 + j]});
      end
   endtask : check_pads
   // Expected pad parameter word after a write, lock kept when set
   function automatic logic [31:0] par_exp(input logic [31:0] old, input logic [31:0] w,
      input logic [31:0] wm, input logic lock);
      logic [31:0] m;
      m = lock ? (wm & ~`GPM_DRV_MASK) : wm;
      par_exp = (w & m) | (old & ~m);
   endfunction : par_exp
   // Hang guard
   initial
   begin
      #2_000_000;
      error_cnt++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      logic [31:0] v, w, d, e1;
      logic [7:0] o, s;
      logic [15:0] held;
      int p;
      void'($urandom(76078));
      do_reset(1'b0);
      rdchk(`GPM_CON0_ADDR, 32'h0000_0000);
      do_reset(1'b1);
      rdchk(`GPM_CON0_ADDR, 32'h0000_1111);
      rdchk(`GPM_CON1_ADDR, 32'h0000_0000);
      rdchk(`GPM_CON2_ADDR, 32'h0000_0000);
      rdchk(`GPM_PAR0_ADDR, 32'h2222_0000);
      rdchk(`GPM_PAR1_ADDR, 32'h2200_0022);
      rdchk(`GPM_PAR2_ADDR, 32'h0000_0000);
      rdchk(32'hffff_f4f0, 32'h0000_0000);
      wr(`GPM_DAT0_ADDR, 32'hff00_0000);
      settle(2);
      check_pads(0, 32'h0000_1111, 8'hff, 8'h00, 8'h0f);
      // Random selectors, directions and peripheral data on every port
      for (int k = 0; k < 12; k++)
      begin
         p = k % 3;
         w = (k == 0) ? 32'hffff_ffff : $urandom();
         d = $urandom();
         fn1_out <= 24'($urandom());
         fn1_drive <= 24'($urandom());
         fn2_out <= 24'($urandom());
         fn2_drive <= 24'($urandom());
         la_out <= 24'($urandom());
         la_drive <= 24'($urandom());
         wr(`GPM_CON0_ADDR + 32'(4 * p), w);
         wr(`GPM_DAT0_ADDR + 32'(16 * p), d & 32'hffff_0000);
         rdchk(`GPM_CON0_ADDR + 32'(4 * p), w & `GPM_CON_MASK);
         settle(2);
         check_pads(p, w, d[31:24], d[23:16], (p == 2) ? 8'h1d : 8'hff);
         // Missing port 2 pads never drive, whatever the selector
         if (p == 2)
            chk("absent pads", 32'he2, {24'h0, pad_oe_n[23:16] & 8'he2});
      end
      wr(`GPM_CON1_ADDR, 32'h0000_0200);
      wr(`GPM_PLL_ADDR, 32'h0000_0003);
      pll_mode <= 2'h3;
      settle(2);
      chk("clock pin enable_n", 32'h1, {31'h0, pad_oe_n[10]});
      wr(`GPM_PLL_ADDR, 32'h0000_0001);
      pll_mode <= 2'h1;
      settle(2);
      check_pads(1, 32'h0000_0200, 8'h00, 8'h00, 8'h04);
      // Live levels while pins sit on the logic array
      wr(`GPM_CON1_ADDR, 32'h3333_3333);
      la_drive <= 24'h00_0000;
      ext_val <= 24'($urandom());
      settle(5);
      rdchk(`GPM_SET1_ADDR, 32'h0000_0000);
      d = {16'h0000, 8'h00, ext_val[15:8]};
      @(posedge core_clk);
      bus_rd <= 1'b1;
      bus_addr <= `GPM_DAT1_ADDR;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      #1;
      chk("live inputs", {24'h0, d[7:0]}, {24'h0, bus_rdata[7:0]});
      chk("array input", {8'h0, pad_in & 24'h1d_ffff}, {8'h0, la_in & 24'h1d_ffff});
      // Set register only raises output bits
      o = 8'($urandom());
      s = 8'($urandom());
      wr(`GPM_DAT1_ADDR, {8'hf0, o, 16'h0000});
      wr(`GPM_SET1_ADDR, {8'hff, s, 16'hffff});
      settle(1);
      @(posedge core_clk);
      bus_rd <= 1'b1;
      bus_addr <= `GPM_DAT1_ADDR;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      #1;
      chk("set outputs", {8'hf0, o | s, 16'h0}, {bus_rdata[31:16], 16'h0});
      // Pads frozen during power saving
      wr(`GPM_CON1_ADDR, 32'h0000_0000);
      wr(`GPM_DAT1_ADDR, {8'hff, o, 16'h0000});
      settle(2);
      held = {pad_oe_n[15:8], pad_out[15:8]};
      @(posedge core_clk);
      low_power <= 1'b1;
      wr(`GPM_DAT1_ADDR, {8'h00, ~o, 16'h0000});
      settle(3);
      chk("frozen pads", {16'h0, held}, {16'h0, pad_oe_n[15:8], pad_out[15:8]});
      @(posedge core_clk);
      low_power <= 1'b0;
      settle(2);
      chk("woken pads", 32'hff, {24'h0, pad_oe_n[15:8]});
      // Pull-up control and one-shot drive strength
      w = 32'h4000_1000;
      e1 = par_exp(32'h2222_0000, w, `GPM_PAR0_WMASK, 1'b0);
      wr(`GPM_PAR0_ADDR, w);
      rdchk(`GPM_PAR0_ADDR, e1);
      settle(2);
      chk("pull-up before data write", 32'h1, {31'h0, pad_pullup_en[3]});
      wr(`GPM_DAT0_ADDR, 32'h0000_0000);
      settle(2);
      chk("pull-up after data write", 32'h0, {31'h0, pad_pullup_en[3]});
      chk("drive strength", {30'h0, e1[30:29]}, {30'h0, pad_drive[15:14]});
      w = 32'h2000_0000;
      wr(`GPM_PAR0_ADDR, w);
      rdchk(`GPM_PAR0_ADDR, par_exp(e1, w, `GPM_PAR0_WMASK, 1'b1));
      wr(`GPM_DAT0_ADDR, 32'h0000_0000);
      settle(2);
      chk("pull-up restored", 32'h1, {31'h0, pad_pullup_en[3]});
      // Port 1 drive bits: first write lands, second is locked out
      e1 = par_exp(32'h2200_0022, 32'h0000_0000, `GPM_PAR1_WMASK, 1'b0);
      wr(`GPM_PAR1_ADDR, 32'h0000_0000);
      wr(`GPM_PAR1_ADDR, 32'hffff_ffff);
      rdchk(`GPM_PAR1_ADDR, par_exp(e1, 32'hffff_ffff, `GPM_PAR1_WMASK, 1'b1));
      // Soft reset with and without the keep bit
      v = $urandom() & `GPM_CON_MASK;
      wr(`GPM_RCFG_ADDR, 32'h0000_0001);
      wr(`GPM_CON2_ADDR, v);
      pulse_soft();
      settle(3);
      rdchk(`GPM_CON2_ADDR, v);
      wr(`GPM_RCFG_ADDR, 32'h0000_0000);
      pulse_soft();
      settle(8);
      rdchk(`GPM_CON2_ADDR, 32'h0000_0000);
      rdchk(`GPM_PAR0_ADDR, 32'h2222_0000);
      print_verdict();
   end
endmodule : tb_top

// *** verilog/gpm_mux.sv ***
// Pin function multiplexer and pad configuration for three ports
//
// What this block does
// - Function select holds a 2-bit selector per pin at bits 4n+1:4n
// - Selector 00 is GPIO; 01, 10, 11 alternates; 11 logic array
// - Pins reset to GPIO except port 0 low pins per reset value
// - Live pin input levels are always readable in the data register
// - Logic array input path from each pin is always connected
// - In power-saving mode pin direction and output level stay frozen
// - With reset configuration bit 0 set, soft reset keeps pin state
// - Pad parameter registers enable or disable each pin pull-up, except port 0 pins 1-2 and port 2 pin 0
// - Twenty pins in three ports, each with its own registers
// - Port 1 pin 2 selector 10 outputs clock, input when mode is 11
// - Debug port pins in JTAG function cannot act as GPIO
// - Port 0 pins 0-3 default follows boot pin level at reset
// - Data register: direction, output, reset pin states, live inputs
// - Set register ones set output bits, zeros leave them
// - Drive strength bits accept only the first write after reset
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "gpm_defines.svh"
module gpm_mux (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata,
   input wire logic [23:0] pad_in,
   output logic [23:0] pad_out,
   output logic [23:0] pad_oe_n,
   output logic [23:0] pad_pullup_en,
   output logic [47:0] pad_drive,
   input wire logic [23:0] fn1_out,
   input wire logic [23:0] fn1_drive,
   input wire logic [23:0] fn2_out,
   input wire logic [23:0] fn2_drive,
   input wire logic [23:0] logic_array_output,
   input wire logic [23:0] la_drive,
   output logic [23:0] logic_array_input,
   input wire logic low_power,
   input wire logic soft_reset
);

   gpm_pkg::gpm_state_t st;
   gpm_pkg::gpm_state_t next_st;

   // Pads that exist on port 2, one bit per pin
   localparam logic [7:0] p2_pad_mask = `GPM_P2_PINS;

   // Merge written bits under a mask
   function automatic logic [31:0] f_merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [31:0] msk
   );
      f_merge = (old & ~msk) | (wd & msk);
   endfunction : f_merge

   // Pull-up enables from a pad parameter word
   function automatic logic [7:0] f_pullup(input logic [31:0] par);
      logic [7:0] r;
      r = '0;
      for (int n = 0; n < 8; n++)
      begin
         r[n] = ~par[n * `GPM_SEL_STRIDE];
      end
      return r;
   endfunction : f_pullup

   // Drive strength fields from a pad parameter word
   function automatic logic [15:0] f_drive(input logic [31:0] par);
      logic [15:0] r;
      r = '0;
      for (int n = 0; n < 8; n++)
      begin
         r[n * 2 +: 2] = par[n * `GPM_SEL_STRIDE + `GPM_DRV_LSB +: 2];
      end
      return r;
   endfunction : f_drive

   // Writable mask of a pad parameter word, drive bits once only
   function automatic logic [31:0] f_par_mask(
      input logic [31:0] wmask,
      input logic lock
   );
      f_par_mask = lock ? (wmask & ~`GPM_DRV_MASK) : wmask;
   endfunction : f_par_mask

   // Outputs come straight from the state register
   assign bus_rdata = st.rdata;
   assign pad_out = st.pad_out;
   assign pad_oe_n = st.pad_oe_n;
   assign pad_pullup_en = st.pullup_en;
   assign pad_drive = st.drive;
   assign logic_array_input = st.la_in;

   // Next state: sync, init capture, bus access, soft reset, pad mux
   always_comb
   begin
      logic [1:0] sel;
      logic o;
      logic d;
      int k;
      sel = `GPM_SEL_GPIO;
      o = 1'b0;
      d = 1'b0;
      k = 0;
      next_st = st;
      next_st.sync_a = pad_in;
      next_st.sync_b = st.sync_a;
      next_st.la_in = st.sync_b;
      next_st.rdata = '0;
      // Capture pin states and boot level once synchronisers settle
      if (!st.init_done)
      begin
         next_st.init_cnt = st.init_cnt + 2'h1;
         if (st.init_cnt == `GPM_INIT_CYCLES)
         begin
            next_st.init_done = 1'b1;
            for (int p = 0; p < 3; p++)
            begin
               next_st.rst_pins[p] = st.sync_b[p * 8 +: 8];
               next_st.pullup_en[p * 8 +: 8] = f_pullup(st.par[p]);
               next_st.drive[p * 16 +: 16] = f_drive(st.par[p]);
            end
            // Boot pin high keeps debug port, low gives GPIO
            if (!st.sync_b[0])
            begin
               next_st.con[0][15:0] = '0;
            end
         end
      end
      // Register writes
      if (bus_wr)
      begin
         if (bus_addr == `GPM_CON0_ADDR)
         begin
            next_st.con[0] = bus_wdata & `GPM_CON_MASK;
         end
         else if (bus_addr == `GPM_CON1_ADDR)
         begin
            next_st.con[1] = bus_wdata & `GPM_CON_MASK;
         end
         else if (bus_addr == `GPM_CON2_ADDR)
         begin
            next_st.con[2] = bus_wdata & `GPM_CON_MASK;
         end
         else if (bus_addr == `GPM_PAR0_ADDR)
         begin
            next_st.par[0] = f_merge(st.par[0], bus_wdata,
               f_par_mask(`GPM_PAR0_WMASK, st.drv_lock[0]));
            next_st.drv_lock[0] = 1'b1;
         end
         else if (bus_addr == `GPM_PAR1_ADDR)
         begin
            next_st.par[1] = f_merge(st.par[1], bus_wdata,
               f_par_mask(`GPM_PAR1_WMASK, st.drv_lock[1]));
            next_st.drv_lock[1] = 1'b1;
         end
         else if (bus_addr == `GPM_PAR2_ADDR)
         begin
            next_st.par[2] = f_merge(st.par[2], bus_wdata,
               f_par_mask(`GPM_PAR2_WMASK, st.drv_lock[2]));
            next_st.drv_lock[2] = 1'b1;
         end
         else if (bus_addr == `GPM_DAT0_ADDR || bus_addr == `GPM_DAT1_ADDR
            || bus_addr == `GPM_DAT2_ADDR)
         begin
            k = (bus_addr == `GPM_DAT0_ADDR) ? 0 :
               (bus_addr == `GPM_DAT1_ADDR) ? 1 : 2;
            next_st.dir[k] = bus_wdata[`GPM_DAT_DIR_LSB +: 8];
            next_st.dout[k] = bus_wdata[`GPM_DAT_OUT_LSB +: 8];
            // Pad parameters take effect on a data write
            next_st.pullup_en[k * 8 +: 8] = f_pullup(st.par[k]);
            next_st.drive[k * 16 +: 16] = f_drive(st.par[k]);
         end
         else if (bus_addr == `GPM_SET0_ADDR)
         begin
            next_st.dout[0] = st.dout[0] | bus_wdata[`GPM_DAT_OUT_LSB +: 8];
         end
         else if (bus_addr == `GPM_SET1_ADDR)
         begin
            next_st.dout[1] = st.dout[1] | bus_wdata[`GPM_DAT_OUT_LSB +: 8];
         end
         else if (bus_addr == `GPM_SET2_ADDR)
         begin
            next_st.dout[2] = st.dout[2] | bus_wdata[`GPM_DAT_OUT_LSB +: 8];
         end
         else if (bus_addr == `GPM_PLL_ADDR)
         begin
            next_st.clk_mode = bus_wdata[1:0];
         end
         else if (bus_addr == `GPM_RCFG_ADDR)
         begin
            next_st.keep_cfg = bus_wdata[`GPM_RCFG_KEEP];
         end
      end
      // Register reads, data valid the following cycle
      if (bus_rd)
      begin
         if (bus_addr == `GPM_CON0_ADDR)
         begin
            next_st.rdata = st.con[0];
         end
         else if (bus_addr == `GPM_CON1_ADDR)
         begin
            next_st.rdata = st.con[1];
         end
         else if (bus_addr == `GPM_CON2_ADDR)
         begin
            next_st.rdata = st.con[2];
         end
         else if (bus_addr == `GPM_PAR0_ADDR)
         begin
            next_st.rdata = st.par[0];
         end
         else if (bus_addr == `GPM_PAR1_ADDR)
         begin
            next_st.rdata = st.par[1];
         end
         else if (bus_addr == `GPM_PAR2_ADDR)
         begin
            next_st.rdata = st.par[2];
         end
         else if (bus_addr == `GPM_DAT0_ADDR)
         begin
            next_st.rdata = {st.dir[0], st.dout[0], st.rst_pins[0],
               st.sync_b[7:0]};
         end
         else if (bus_addr == `GPM_DAT1_ADDR)
         begin
            next_st.rdata = {st.dir[1], st.dout[1], st.rst_pins[1],
               st.sync_b[15:8]};
         end
         else if (bus_addr == `GPM_DAT2_ADDR)
         begin
            next_st.rdata = {st.dir[2], st.dout[2], st.rst_pins[2],
               st.sync_b[23:16]};
         end
         else if (bus_addr == `GPM_PLL_ADDR)
         begin
            next_st.rdata = 32'(st.clk_mode);
         end
         else if (bus_addr == `GPM_RCFG_ADDR)
         begin
            next_st.rdata = 32'(st.keep_cfg);
         end
      end
      // Watchdog or software reset, unless retention is set
      if (soft_reset && !st.keep_cfg)
      begin
         next_st.con[0] = `GPM_CON0_RST;
         next_st.con[1] = `GPM_CON_RST;
         next_st.con[2] = `GPM_CON_RST;
         next_st.par[0] = `GPM_PAR0_RST;
         next_st.par[1] = `GPM_PAR1_RST;
         next_st.par[2] = `GPM_PAR2_RST;
         next_st.dir = '0;
         next_st.dout = '0;
         next_st.drv_lock = '0;
         next_st.init_cnt = '0;
         next_st.init_done = 1'b0;
      end
      // Pad mux, frozen during power saving
      if (!low_power)
      begin
         for (int p = 0; p < 3; p++)
         begin
            for (int n = 0; n < 8; n++)
            begin
               k = p * 8 + n;
               sel = st.con[p][n * `GPM_SEL_STRIDE +: 2];
               case (sel)
                  `GPM_SEL_GPIO:
                  begin
                     o = st.dout[p][n];
                     d = st.dir[p][n];
                  end
                  `GPM_SEL_FN1:
                  begin
                     o = fn1_out[k];
                     d = fn1_drive[k];
                  end
                  `GPM_SEL_FN2:
                  begin
                     o = fn2_out[k];
                     d = fn2_drive[k];
                     if (k == `GPM_CLK_PIN)
                     begin
                        d = (st.clk_mode != `GPM_CLK_MODE_EXT);
                     end
                  end
                  default:
                  begin
                     o = logic_array_output[k];
                     d = la_drive[k];
                  end
               endcase
               // Port 2 has no pad behind pins 1, 5, 6 and 7
               if (p == 2 && !p2_pad_mask[n])
               begin
                  d = 1'b0;
               end
               next_st.pad_out[k] = o;
               next_st.pad_oe_n[k] = ~d;
            end
         end
      end
   end

   // State register
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st <= '0;
         st.con[0] <= `GPM_CON0_RST;
         st.par[0] <= `GPM_PAR0_RST;
         st.par[1] <= `GPM_PAR1_RST;
         st.par[2] <= `GPM_PAR2_RST;
         st.clk_mode <= `GPM_CLK_MODE_RST;
         st.pad_oe_n <= '1;
         st.pullup_en <= '1;
      end
      else
      begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_clk_sel;
      st.con[1][9:8] == `GPM_SEL_FN2 && !low_power;
   endsequence

   sequence s_clk_ext;
      s_clk_sel ##0 st.clk_mode == `GPM_CLK_MODE_EXT;
   endsequence

   a_select_reserved: assert property (
      bus_wr && bus_addr == `GPM_CON1_ADDR && !soft_reset
      |=> st.con[1] == ($past(bus_wdata) & `GPM_CON_MASK))
      else $error("select register reserved bits not cleared");

   a_gpio_route: assert property (
      st.con[1][1:0] == `GPM_SEL_GPIO && !low_power
      |=> pad_out[8] == $past(st.dout[1][0])
         && pad_oe_n[8] == !$past(st.dir[1][0]))
      else $error("GPIO selector does not route data register");

   a_boot_default: assert property (
      $rose(st.init_done) && !$past(bus_wr)
      |-> st.con[0][15:0] == ($past(st.sync_b[0]) ? `GPM_JTAG_CON : 16'h0000))
      else $error("port 0 default ignores boot level");

   a_live_input: assert property (
      bus_rd && bus_addr == `GPM_DAT2_ADDR
      |=> bus_rdata[7:0] == $past(st.sync_b[23:16]))
      else $error("live input not read back");

   a_array_input: assert property (
      !$past(rst, 3) |-> logic_array_input == $past(pad_in, 3))
      else $error("logic array input path broken");

   a_power_hold: assert property (
      low_power |=> $stable(pad_out) && $stable(pad_oe_n))
      else $error("pads changed in power saving");

   a_soft_keep: assert property (
      soft_reset && st.keep_cfg && !bus_wr |=> $stable(st.con) && $stable(st.dout))
      else $error("retained state lost on soft reset");

   a_set_bits: assert property (
      bus_wr && bus_addr == `GPM_SET0_ADDR && !soft_reset
      |=> st.dout[0] == ($past(st.dout[0]) | $past(bus_wdata[23:16])))
      else $error("set register did not set output bits");

   a_drive_lock: assert property (
      st.drv_lock[1] && !soft_reset
      |=> (st.par[1] & `GPM_DRV_MASK) == ($past(st.par[1]) & `GPM_DRV_MASK))
      else $error("drive strength changed after first write");

   a_clock_input: assert property (
      s_clk_ext |=> pad_oe_n[`GPM_CLK_PIN])
      else $error("clock pin drives in external clock mode");

endmodule : gpm_mux
